// ---- hdl/occ_osc_ctrl.sv ----
// Oscillator control, trim and crystal start-up logic
//
// Operation
// - pending flag high until new source stable
// - fast keep-running keeps oscillator powered always
// - slow keep-running keeps oscillator powered always
// - internal oscillator output gated unless requested
// - gate opens four oscillator cycles after request
// - keep-running skips analog start-up wait
// - seven-bit frequency trim, factory load by fuse
// - four-bit slope trim, factory load by fuse
// - lock flag blocks both trim registers
// - lock flag loaded from fuse at reset
// - crystal type/start-up ignore writes while enabled/stable
// - start-up codes give 1k/16k/32k/64k cycles
// - external clock skips crystal start-up wait
// - type bit selects crystal or external clock
// - enabled crystal runs always with keep-running, else requested
// - crystal output only to requesting consumers
// - crystal delivered two to three cycles after request
// - enable claims crystal pins, freezes type/start-up
// - crystal enable and keep-running are write protected
// - stable flags read zero while unrequested, except the external clock flag
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module occ_osc_ctrl #(
   parameter int SU_1K = occ_pkg::XT_SU_1K,
   parameter int SU_16K = occ_pkg::XT_SU_16K,
   parameter int SU_32K = occ_pkg::XT_SU_32K,
   parameter int SU_64K = occ_pkg::XT_SU_64K
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire occ_pkg::occ_bus_req_t bus_req,
   output logic [7:0] rdata_q,
   // Protection and fuses
   input wire logic ccp_unlock,
   input wire logic fuse_freq_choice,
   input wire logic fuse_trim_freeze,
   // Consumer requests and main clock choice
   input wire logic fast_req,
   input wire logic slow_req,
   input wire logic xtal_req,
   input wire occ_pkg::occ_src_t main_sel,
   input wire logic ext_clk_started,
   // Oscillator feedback, one tick per oscillator cycle
   input wire logic fast_tick,
   input wire logic slow_tick,
   input wire logic xtal_tick,
   input wire logic fast_analog_ready,
   input wire logic slow_analog_ready,
   // Oscillator control outputs
   output logic fast_power_q,
   output logic slow_power_q,
   output logic xtal_power_q,
   output logic fast_gate_q,
   output logic slow_gate_q,
   output logic xtal_gate_q,
   output logic crystal_pin_override_q,
   output logic [6:0] fast_freq_trim_q,
   output logic [3:0] fast_temp_slope_trim_q,
   output logic main_switch_pending_q,
   output occ_pkg::occ_src_t main_active_q
);
   // Parameter sanity
   initial
   begin
      if (SU_1K < 1 || SU_16K < 1 || SU_32K < 1 || SU_64K < 1 || SU_64K >= (1 << occ_pkg::SU_W))
         $error("occ_osc_ctrl: start-up counts out of range");
   end

   logic fast_keep_q, slow_keep_q;
   logic xt_enable_q, xt_keep_q, xt_sel_q;
   logic [1:0] xt_crystal_startup_count_q;
   logic trim_lock_q, init_done_q;
   logic xt_started_q;
   logic [occ_pkg::SU_W-1:0] xt_su_cnt_q;
   logic [1:0] xt_gate_cnt_q;
   logic wr_ok;
   logic [1:0] int_req, int_keep, int_tick, int_ready;
   logic [1:0] int_power, int_gate;
   logic xreq;
   logic [occ_pkg::SU_W-1:0] su_target;
   logic [7:0] status;

   // Every register here is protected: no window, no write
   assign wr_ok = bus_req.wr && ccp_unlock;

   // Fuse image captured on the first clock after reset release
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         init_done_q <= 1'b0;
         trim_lock_q <= 1'b0;
      end
      else if (!init_done_q)
      begin
         init_done_q <= 1'b1;
         trim_lock_q <= fuse_trim_freeze;
      end
   end

   // Trim registers; the lock flag itself is never writable
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         fast_freq_trim_q <= occ_pkg::FREQ_TRIM_RESET;
         fast_temp_slope_trim_q <= occ_pkg::TEMP_TRIM_RESET;
      end
      else if (!init_done_q)
      begin
         fast_freq_trim_q <= fuse_freq_choice ? occ_pkg::FACT_FREQ_TRIM_1 : occ_pkg::FACT_FREQ_TRIM_0;
         fast_temp_slope_trim_q <= fuse_freq_choice ? occ_pkg::FACT_TEMP_TRIM_1
                                                    : occ_pkg::FACT_TEMP_TRIM_0;
      end
      else if (wr_ok && !trim_lock_q)
      begin
         if (bus_req.addr == occ_pkg::OFS_FAST_FREQ)
            fast_freq_trim_q <= bus_req.wdata[6:0];
         if (bus_req.addr == occ_pkg::OFS_FAST_TEMP)
            fast_temp_slope_trim_q <= bus_req.wdata[3:0];
      end
   end

   // Internal oscillator keep-running bits
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         fast_keep_q <= occ_pkg::CTRL_RESET[occ_pkg::KEEP_RUN_BIT];
         slow_keep_q <= occ_pkg::CTRL_RESET[occ_pkg::KEEP_RUN_BIT];
      end
      else if (wr_ok)
      begin
         if (bus_req.addr == occ_pkg::OFS_FAST_CTRL)
            fast_keep_q <= bus_req.wdata[occ_pkg::KEEP_RUN_BIT];
         if (bus_req.addr == occ_pkg::OFS_SLOW_CTRL)
            slow_keep_q <= bus_req.wdata[occ_pkg::KEEP_RUN_BIT];
      end
   end

   // Crystal control; type and start-up frozen while enabled or stable
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         xt_enable_q <= occ_pkg::CTRL_RESET[occ_pkg::XT_ENABLE_BIT];
         xt_keep_q <= occ_pkg::CTRL_RESET[occ_pkg::KEEP_RUN_BIT];
         xt_sel_q <= occ_pkg::CTRL_RESET[occ_pkg::XT_SEL_BIT];
         xt_crystal_startup_count_q <= occ_pkg::CTRL_RESET[occ_pkg::XT_CRYSTAL_STARTUP_COUNT_LO +: 2];
      end
      else if (wr_ok && bus_req.addr == occ_pkg::OFS_XTAL_CTRL)
      begin
         xt_enable_q <= bus_req.wdata[occ_pkg::XT_ENABLE_BIT];
         xt_keep_q <= bus_req.wdata[occ_pkg::KEEP_RUN_BIT];
         if (!xt_enable_q && !xtal_gate_q)
         begin
            xt_sel_q <= bus_req.wdata[occ_pkg::XT_SEL_BIT];
            xt_crystal_startup_count_q <= bus_req.wdata[occ_pkg::XT_CRYSTAL_STARTUP_COUNT_LO +: 2];
         end
      end
   end

   // Pins follow the enable bit
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         crystal_pin_override_q <= 1'b0;
      else
         crystal_pin_override_q <= xt_enable_q;
   end

   // The main clock counts as one more consumer
   assign int_req[0] = fast_req || main_sel == occ_pkg::OCC_SRC_FAST;
   assign int_req[1] = slow_req || main_sel == occ_pkg::OCC_SRC_SLOW;
   assign xreq = xtal_req || main_sel == occ_pkg::OCC_SRC_XTAL;
   assign int_keep = {slow_keep_q, fast_keep_q};
   assign int_tick = {slow_tick, fast_tick};
   assign int_ready = {slow_analog_ready, fast_analog_ready};

   // Internal oscillator power and gate, one slice per oscillator
   for (genvar i = 0; i < 2; i++)
   begin : g_int
      logic power_q, gate_q;
      logic [2:0] cnt_q;
      // Power does not depend on sleep mode at all
      always_ff @(posedge ref_clk or posedge rst)
      begin
         if (rst)
            power_q <= 1'b0;
         else
            power_q <= int_keep[i] || int_req[i];
      end
      // Already running oscillators see ready at once, so only the gate delay remains
      always_ff @(posedge ref_clk or posedge rst)
      begin
         if (rst)
         begin
            gate_q <= 1'b0;
            cnt_q <= 3'h0;
         end
         else if (!int_req[i])
         begin
            gate_q <= 1'b0;
            cnt_q <= 3'h0;
         end
         else if (!gate_q && power_q && int_ready[i] && int_tick[i])
         begin
            if (cnt_q == 3'(occ_pkg::GATE_DELAY - 1))
               gate_q <= 1'b1;
            cnt_q <= cnt_q + 3'h1;
         end
      end
      assign int_power[i] = power_q;
      assign int_gate[i] = gate_q;
   end
   assign fast_power_q = int_power[0];
   assign slow_power_q = int_power[1];
   assign fast_gate_q = int_gate[0];
   assign slow_gate_q = int_gate[1];

   // Start-up length from the code
   always_comb
   begin
      unique case (xt_crystal_startup_count_q)
         2'h0: su_target = occ_pkg::SU_W'(SU_1K);
         2'h1: su_target = occ_pkg::SU_W'(SU_16K);
         2'h2: su_target = occ_pkg::SU_W'(SU_32K);
         2'h3: su_target = occ_pkg::SU_W'(SU_64K);
      endcase
   end

   // Crystal power and initial start-up
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         xtal_power_q <= 1'b0;
         xt_started_q <= 1'b0;
         xt_su_cnt_q <= '0;
      end
      else
      begin
         xtal_power_q <= xt_enable_q && (xt_keep_q || xreq);
         if (!xtal_power_q)
         begin
            xt_started_q <= 1'b0;
            xt_su_cnt_q <= '0;
         end
         else if (xt_sel_q)
            xt_started_q <= 1'b1;
         else if (!xt_started_q && xtal_tick)
         begin
            if (xt_su_cnt_q == su_target - occ_pkg::SU_W'(1))
               xt_started_q <= 1'b1;
            xt_su_cnt_q <= xt_su_cnt_q + occ_pkg::SU_W'(1);
         end
      end
   end

   // Crystal delivery gate, short once started
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         xtal_gate_q <= 1'b0;
         xt_gate_cnt_q <= 2'h0;
      end
      else if (!xreq || !xtal_power_q)
      begin
         xtal_gate_q <= 1'b0;
         xt_gate_cnt_q <= 2'h0;
      end
      else if (!xtal_gate_q && xt_started_q && xtal_tick)
      begin
         if (xt_gate_cnt_q == 2'(occ_pkg::XTAL_FAST_DELAY - 1))
            xtal_gate_q <= 1'b1;
         xt_gate_cnt_q <= xt_gate_cnt_q + 2'h1;
      end
   end

   // Main clock change-over waits for the new source's gate, or ext_clk_started for the external clock
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         main_active_q <= occ_pkg::OCC_SRC_FAST;
         main_switch_pending_q <= 1'b0;
      end
      else if (main_sel != main_active_q)
      begin
         main_switch_pending_q <= 1'b1;
         if (status[occ_pkg::ST_FAST_BIT + 32'(main_sel)] || (main_sel == occ_pkg::OCC_SRC_EXT && ext_clk_started))
         begin
            main_active_q <= main_sel;
            main_switch_pending_q <= 1'b0;
         end
      end
      else
         main_switch_pending_q <= 1'b0;
   end

   // Stable means delivered, so it drops when the request drops; the external clock bit follows ext_clk_started alone
   always_comb
   begin
      status = 8'h00;
      status[occ_pkg::ST_PENDING_BIT] = main_switch_pending_q;
      status[occ_pkg::ST_FAST_BIT] = fast_gate_q;
      status[occ_pkg::ST_SLOW_BIT] = slow_gate_q;
      status[occ_pkg::ST_XTAL_BIT] = xtal_gate_q;
      status[occ_pkg::ST_EXT_BIT] = ext_clk_started;
   end

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rdata_q <= 8'h00;
      else if (!bus_req.rd)
         rdata_q <= 8'h00;
      else
      begin
         unique case (bus_req.addr)
            occ_pkg::OFS_STATUS: rdata_q <= status;
            occ_pkg::OFS_FAST_CTRL: rdata_q <= 8'(fast_keep_q) << occ_pkg::KEEP_RUN_BIT;
            occ_pkg::OFS_FAST_FREQ: rdata_q <= {1'b0, fast_freq_trim_q};
            occ_pkg::OFS_FAST_TEMP: rdata_q <= {trim_lock_q, 3'h0, fast_temp_slope_trim_q};
            occ_pkg::OFS_SLOW_CTRL: rdata_q <= 8'(slow_keep_q) << occ_pkg::KEEP_RUN_BIT;
            occ_pkg::OFS_XTAL_CTRL: rdata_q <= {2'h0, xt_crystal_startup_count_q, 1'b0, xt_sel_q, xt_keep_q, xt_enable_q};
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_pending_sets: assert property ($changed(main_sel) && main_sel != main_active_q
      |=> main_switch_pending_q || main_active_q == $past(main_sel))
      else $error("pending flag not raised on source change");
   a_fast_keep_power: assert property (fast_keep_q |-> ##1 fast_power_q)
      else $error("fast oscillator off despite keep-running");
   a_slow_keep_power: assert property (slow_keep_q |-> ##1 slow_power_q)
      else $error("slow oscillator off despite keep-running");
   a_gate_needs_req: assert property (!int_req[0] |=> !fast_gate_q)
      else $error("fast gate open without request");
   a_gate_four_ticks: assert property ($rose(fast_gate_q) |-> g_int[0].cnt_q == 3'(occ_pkg::GATE_DELAY))
      else $error("fast gate opened after wrong tick count");
   a_trim_lock_hold: assert property (trim_lock_q && init_done_q |=> $stable(fast_freq_trim_q)
      && $stable(fast_temp_slope_trim_q))
      else $error("trim changed while locked");
   a_xtal_cfg_frozen: assert property (xt_enable_q |=> $stable(xt_sel_q) && $stable(xt_crystal_startup_count_q))
      else $error("crystal type or start-up changed while enabled");
   a_ext_skip_su: assert property (xtal_power_q && xt_sel_q |=> xt_started_q)
      else $error("external clock waited for start-up");
   a_xtal_fast_gate: assert property (xtal_gate_q |-> $past(xreq) && xt_started_q)
      else $error("crystal delivered unrequested or unstarted");
   a_xtal_two_ticks: assert property ($rose(xtal_gate_q) |-> xt_gate_cnt_q == 2'(occ_pkg::XTAL_FAST_DELAY))
      else $error("crystal gate opened after wrong tick count");
   a_locked_write: assert property (bus_req.wr && !ccp_unlock |=> $stable(xt_enable_q) && $stable(fast_keep_q))
      else $error("protected bit written without unlock");

   c_fast_open: cover property (fast_keep_q ##1 $rose(fast_gate_q));
   c_xtal_start: cover property ($rose(xt_started_q) && !xt_sel_q);
   c_main_switch: cover property ($fell(main_switch_pending_q));
   c_write_refused: cover property (wr_ok && xt_enable_q && bus_req.addr == occ_pkg::OFS_XTAL_CTRL);
endmodule

// ---- shared/occ_pkg.sv ----
// Shared constants and carrier types for the oscillator control block
package occ_pkg;
   // Register offsets
   localparam logic [7:0] OFS_STATUS = 8'h03;
   localparam logic [7:0] OFS_FAST_CTRL = 8'h10;
   localparam logic [7:0] OFS_FAST_FREQ = 8'h11;
   localparam logic [7:0] OFS_FAST_TEMP = 8'h12;
   localparam logic [7:0] OFS_SLOW_CTRL = 8'h18;
   localparam logic [7:0] OFS_XTAL_CTRL = 8'h1c;
   // Field positions
   localparam int KEEP_RUN_BIT = 1;
   localparam int XT_ENABLE_BIT = 0;
   localparam int XT_SEL_BIT = 2;
   localparam int XT_CRYSTAL_STARTUP_COUNT_LO = 4;
   localparam int TRIM_LOCK_BIT = 7;
   localparam int ST_PENDING_BIT = 0;
   localparam int ST_FAST_BIT = 4;
   localparam int ST_SLOW_BIT = 5;
   localparam int ST_XTAL_BIT = 6;
   localparam int ST_EXT_BIT = 7;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [6:0] FREQ_TRIM_RESET = 7'h00;
   localparam logic [3:0] TEMP_TRIM_RESET = 4'h0;
   // Factory trim images, one per frequency fuse choice
   localparam logic [6:0] FACT_FREQ_TRIM_0 = 7'h40;
   localparam logic [6:0] FACT_FREQ_TRIM_1 = 7'h40;
   localparam logic [3:0] FACT_TEMP_TRIM_0 = 4'h8;
   localparam logic [3:0] FACT_TEMP_TRIM_1 = 4'h8;
   // Timing, in oscillator cycles
   localparam int GATE_DELAY = 4;
   localparam int XTAL_FAST_DELAY = 2;
   localparam int XT_SU_1K = 1024;
   localparam int XT_SU_16K = 16384;
   localparam int XT_SU_32K = 32768;
   localparam int XT_SU_64K = 65536;
   localparam int SU_W = 17;
   // Main clock sources
   typedef enum logic [1:0] {
      OCC_SRC_FAST = 2'b00,
      OCC_SRC_SLOW = 2'b01,
      OCC_SRC_XTAL = 2'b10,
      OCC_SRC_EXT = 2'b11
   } occ_src_t;
   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } occ_bus_req_t;
endpackage

// ---- tb/occ_osc_model.sv ----
// Behavioural oscillator at the block's far side: ticks and analog ready
`timescale 1ns/10ps
module occ_osc_model #(
   parameter int DIV = 5,
   parameter int RDY = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Power in, oscillator out
   input wire logic power,
   output logic tick,
   output logic ready
);
   int cnt;
   int age;
   // Unpowered: no ticks, ready drops, so start-up begins again
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst || !power)
      begin
         cnt <= 0;
         age <= 0;
         tick <= 1'b0;
         ready <= 1'b0;
      end
      else
      begin
         cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
         tick <= (cnt == DIV - 1);
         age <= (age < RDY) ? age + 1 : age;
         ready <= (age >= RDY);
      end
   end
endmodule

// ---- tb/tb_oscillator_control_calibration.sv ----
// Self-checking bench for the oscillator control block
`timescale 1ns/10ps
module tb_oscillator_control_calibration;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   occ_pkg::occ_bus_req_t bus_req = '0;
   logic [7:0] rdata_q;
   logic ccp_unlock = 1'b0;
   logic fuse_freq_choice = 1'b0;
   logic fuse_trim_freeze = 1'b0;
   logic fast_req = 1'b0;
   logic slow_req = 1'b0;
   logic xtal_req = 1'b0;
   occ_pkg::occ_src_t main_sel = occ_pkg::OCC_SRC_FAST;
   logic ext_clk_started = 1'b0;
   logic fast_tick, slow_tick, xtal_tick, fast_rdy, slow_rdy;
   logic fast_power_q, slow_power_q, xtal_power_q;
   logic fast_gate_q, slow_gate_q, xtal_gate_q, pin_q, pend_q;
   logic [6:0] freq_q;
   logic [3:0] slope_q;
   occ_pkg::occ_src_t act_q;
   int error_cnt = 0;
   int total_checks = 0;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   logic rd_seen = 1'b0;
   int ft = 0;
   int st = 0;
   int xt = 0;
   int n;
   int n0;
   int su[4] = '{4, 8, 12, 16};
   logic [6:0] fq;
   logic [3:0] sl;
   logic [7:0] r;

   // 40 MHz
   always #12.5 ref_clk = ~ref_clk;

   // Short start-up counts keep the crystal cases quick
   occ_osc_ctrl #(.SU_1K(4), .SU_16K(8), .SU_32K(12), .SU_64K(16)) occ_osc_ctrl_inst (
      .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rdata_q(rdata_q), .ccp_unlock(ccp_unlock),
      .fuse_freq_choice(fuse_freq_choice), .fuse_trim_freeze(fuse_trim_freeze),
      .fast_req(fast_req), .slow_req(slow_req), .xtal_req(xtal_req), .main_sel(main_sel),
      .ext_clk_started(ext_clk_started), .fast_tick(fast_tick), .slow_tick(slow_tick),
      .xtal_tick(xtal_tick), .fast_analog_ready(fast_rdy), .slow_analog_ready(slow_rdy),
      .fast_power_q(fast_power_q), .slow_power_q(slow_power_q), .xtal_power_q(xtal_power_q),
      .fast_gate_q(fast_gate_q), .slow_gate_q(slow_gate_q), .xtal_gate_q(xtal_gate_q),
      .crystal_pin_override_q(pin_q), .fast_freq_trim_q(freq_q),
      .fast_temp_slope_trim_q(slope_q), .main_switch_pending_q(pend_q), .main_active_q(act_q));

   // Far side oscillators, fast, slow and crystal rates
   occ_osc_model fast_occ_osc_model_inst (.ref_clk(ref_clk), .rst(rst),
      .power(fast_power_q), .tick(fast_tick), .ready(fast_rdy));
   occ_osc_model #(.DIV(7)) slow_occ_osc_model_inst (.ref_clk(ref_clk), .rst(rst),
      .power(slow_power_q), .tick(slow_tick), .ready(slow_rdy));
   occ_osc_model xtal_occ_osc_model_inst (.ref_clk(ref_clk), .rst(rst),
      .power(xtal_power_q), .tick(xtal_tick), .ready());

   // Tick tallies time the gate openings
   always @(posedge ref_clk)
   begin
      ft <= ft + fast_tick;
      st <= st + slow_tick;
      xt <= xt + xtal_tick;
      rd_seen <= bus_req.rd;
   end

   // Read data stands only in the cycle after the strobe
   always @(negedge ref_clk)
   begin
      if (rd_seen)
      begin
         e = exp_q.pop_front();
         check(rdata_q & e[15:8], e[7:0]);
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d);
      exp_q.push_back({m, d & m});
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
   endtask

   // Waits land past the edge so registered outputs have settled
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   function automatic logic sig(input int w);
      case (w)
         0: return slow_gate_q;
         1: return xtal_gate_q;
         2: return pend_q;
         3: return fast_gate_q;
         4: return slow_tick;
         default: return xtal_tick;
      endcase
   endfunction

   task automatic wait_for(input int w, input logic lvl);
      n = 0;
      while (sig(w) !== lvl && n < 2000)
      begin
         cyc(1);
         n++;
      end
      check(8'(n < 2000), 8'h01);
   endtask

   task automatic do_reset(input logic frz);
      @(posedge ref_clk);
      rst <= 1'b1;
      fuse_trim_freeze <= frz;
      fuse_freq_choice <= 1'($urandom);
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      cyc(2);
      fq = fuse_freq_choice ? occ_pkg::FACT_FREQ_TRIM_1 : occ_pkg::FACT_FREQ_TRIM_0;
      sl = fuse_freq_choice ? occ_pkg::FACT_TEMP_TRIM_1 : occ_pkg::FACT_TEMP_TRIM_0;
   endtask

   task automatic give_verdict;
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      void'($urandom(74));
      do_reset(1'b0);
      // Reset image, plus an unmapped hole
      rd(occ_pkg::OFS_FAST_CTRL, 8'hff, 8'h00);
      rd(occ_pkg::OFS_FAST_FREQ, 8'hff, {1'b0, fq});
      rd(occ_pkg::OFS_FAST_TEMP, 8'hff, {4'h0, sl});
      rd(occ_pkg::OFS_SLOW_CTRL, 8'hff, 8'h00);
      rd(occ_pkg::OFS_XTAL_CTRL, 8'hff, 8'h00);
      rd(8'h05, 8'hff, 8'h00);
      // Locked window drops writes; lock bit cannot be written
      r = {1'b0, fq ^ 7'($urandom | 1)};
      wr(occ_pkg::OFS_FAST_FREQ, r);
      rd(occ_pkg::OFS_FAST_FREQ, 8'hff, {1'b0, fq});
      ccp_unlock <= 1'b1;
      wr(occ_pkg::OFS_FAST_FREQ, r);
      wr(occ_pkg::OFS_FAST_TEMP, 8'h80 | r);
      rd(occ_pkg::OFS_FAST_FREQ, 8'hff, r);
      rd(occ_pkg::OFS_FAST_TEMP, 8'hff, {4'h0, r[3:0]});
      cyc(1);
      check({1'b0, freq_q}, r);
      check({4'h0, slope_q}, {4'h0, r[3:0]});
      // Slow keep-running: powered, but gated until requested
      wr(occ_pkg::OFS_SLOW_CTRL, 8'h02);
      cyc(40);
      check({6'h0, slow_power_q, slow_gate_q}, 8'h02);
      rd(occ_pkg::OFS_STATUS, 8'h20, 8'h00);
      wait_for(4, 1'b1);
      cyc(1);
      n0 = st;
      slow_req <= 1'b1;
      wait_for(0, 1'b1);
      check(8'(st - n0), 8'h04);
      slow_req <= 1'b0;
      wait_for(0, 1'b0);
      // Change-over to slow, then to the external clock
      wr(occ_pkg::OFS_FAST_CTRL, 8'h02);
      main_sel <= occ_pkg::OCC_SRC_SLOW;
      rd(occ_pkg::OFS_STATUS, 8'h01, 8'h01);
      wait_for(2, 1'b0);
      check({6'h0, act_q}, {6'h0, occ_pkg::OCC_SRC_SLOW});
      rd(occ_pkg::OFS_STATUS, 8'h31, 8'h20);
      check({6'h0, fast_power_q, fast_gate_q}, 8'h02);
      wr(occ_pkg::OFS_FAST_CTRL, 8'h00);
      cyc(3);
      check({7'h0, fast_power_q}, 8'h00);
      // Peripheral request alone powers and opens the fast oscillator
      fast_req <= 1'b1;
      wait_for(3, 1'b1);
      check({7'h0, fast_power_q}, 8'h01);
      fast_req <= 1'b0;
      wait_for(3, 1'b0);
      main_sel <= occ_pkg::OCC_SRC_EXT;
      rd(occ_pkg::OFS_STATUS, 8'h81, 8'h01);
      ext_clk_started <= 1'b1;
      wait_for(2, 1'b0);
      check({6'h0, act_q}, {6'h0, occ_pkg::OCC_SRC_EXT});
      main_sel <= occ_pkg::OCC_SRC_FAST;
      cyc(2);
      wait_for(2, 1'b0);
      // Crystal: every start-up code, frozen fields, safe reconfiguration
      for (int c = 0; c < 4; c++)
      begin
         wr(occ_pkg::OFS_XTAL_CTRL, 8'(c << 4) | 8'h01);
         cyc(20);
         check({7'h0, xtal_power_q}, 8'h00);
         n0 = xt;
         xtal_req <= 1'b1;
         wait_for(1, 1'b1);
         check(8'(xt - n0 >= su[c] && xt - n0 <= su[c] + 3), 8'h01);
         check({7'h0, pin_q}, 8'h01);
         wr(occ_pkg::OFS_XTAL_CTRL, 8'(c << 4) ^ 8'h35);
         rd(occ_pkg::OFS_XTAL_CTRL, 8'h37, 8'(c << 4) | 8'h01);
         xtal_req <= 1'b0;
         wr(occ_pkg::OFS_XTAL_CTRL, 8'h00);
         wait_for(1, 1'b0);
      end
      // External clock type skips the start-up wait
      wr(occ_pkg::OFS_XTAL_CTRL, 8'h07);
      n0 = xt;
      xtal_req <= 1'b1;
      wait_for(1, 1'b1);
      check(8'(xt - n0 <= 3), 8'h01);
      xtal_req <= 1'b0;
      cyc(5);
      check({6'h0, xtal_power_q, xtal_gate_q}, 8'h02);
      wait_for(5, 1'b1);
      cyc(1);
      n0 = xt;
      xtal_req <= 1'b1;
      wait_for(1, 1'b1);
      check(8'(xt - n0 >= 2 && xt - n0 <= 3), 8'h01);
      // Stable crystal refuses type and start-up changes
      wr(occ_pkg::OFS_XTAL_CTRL, 8'h33);
      rd(occ_pkg::OFS_XTAL_CTRL, 8'h37, 8'h07);
      // Locked window: an attempt to switch the crystal off must be dropped
      ccp_unlock <= 1'b0;
      xtal_req <= 1'b0;
      wr(occ_pkg::OFS_XTAL_CTRL, 8'h00);
      cyc(3);
      check({6'h0, xtal_power_q, pin_q}, 8'h03);
      // Fuse freeze holds the frequency trim against software
      do_reset(1'b1);
      ccp_unlock <= 1'b1;
      wr(occ_pkg::OFS_FAST_FREQ, {1'b0, ~fq});
      rd(occ_pkg::OFS_FAST_TEMP, 8'h80, 8'h80);
      rd(occ_pkg::OFS_FAST_FREQ, 8'hff, {1'b0, fq});
      cyc(2);
      give_verdict();
   end

   // The run needs under a thousand cycles; this cuts a hang short
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      give_verdict();
   end
endmodule
